// >>> cmp_consts.vh
// constants for the dual comparator control block
// assumes plain verilog-2005 users that include this header by its bare name
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

// register bus
`define CMP_ADDR_W 4
`define CMP_CTRL_ADDR 4'h0
`define CMP_CTRL_RESET 8'h07

// control register field positions
`define CMP_BIT_CMP2_RESULT 7
`define CMP_BIT_CMP1_RESULT 6
`define CMP_BIT_CMP2_INV 5
`define CMP_BIT_CMP1_INV 4
`define CMP_BIT_INPUT_SWITCH 3
`define CMP_MODE_HI 2
`define CMP_MODE_LO 0
`define CMP_WRITABLE_MASK 8'h3F

// mode codes
`define CMP_MODE_MUX4_VREF 3'h6
`define CMP_MODE_OFF 3'h7
`define CMP_MODE_PINOUT 3'h3

// analog source select codes
`define CMP_SRC_RA0 3'h0
`define CMP_SRC_RA1 3'h1
`define CMP_SRC_RA2 3'h2
`define CMP_SRC_RA3 3'h3
`define CMP_SRC_RA4 3'h4
`define CMP_SRC_RA5 3'h5
`define CMP_SRC_VREF 3'h6
`define CMP_SRC_NONE 3'h7

`endif

// >>> cmp_channel.v
// one comparator channel: register-path synchroniser, polarity and result flop
// assumes raw_level comes straight from an analog comparator, asynchronous to clk
`timescale 1ns/100ps

module cmp_channel (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // analog side
  input wire raw_level,
  // control
  input wire enable,
  input wire invert,
  // results
  output reg result,
  output wire pin_level
);

  reg sync1;
  reg sync2;
  reg sync3;
  reg stable;

  // three-stage synchroniser, change accepted once stages two and three agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      stable <= 1'b0;
    end else begin
      sync1 <= raw_level;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        stable <= sync3;
      end
    end
  end

  // polarity applied to the register copy; a disabled comparator reads 0
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result <= 1'b0;
    end else begin
      result <= enable & (stable ^ invert);
    end
  end

  // pin copy bypasses the synchroniser on purpose
  assign pin_level = enable & (raw_level ^ invert);

endmodule // cmp_channel

// >>> dual_comparator_control.v
// dual comparator control: control register, input routing, results and pin muxes
// assumes analog comparators and the input muxes sit outside, steered by the
// select outputs; port direction latches for the pins live elsewhere
// assumes software can live with register results that trail the comparators by
// five clocks; the pin copies carry no such delay and are not filtered at all
// assumes reset puts the register in the off mode before any access
// assumes a single register at offset zero; other offsets read zero and ignore writes
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "cmp_consts.vh"

module dual_comparator_control (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // analog comparator outputs
  input wire cmp1_raw,
  input wire cmp2_raw,
  // analog input routing
  output reg [2:0] cmp1_noninverting_input,
  output reg [2:0] cmp1_inverting_input,
  output reg [2:0] cmp2_noninverting_input,
  output reg [2:0] cmp2_inverting_input,
  output wire cmp1_enable,
  output wire cmp2_enable,
  // pin output path
  output wire ra4_cmp_select,
  output wire ra5_cmp_select,
  output wire ra4_cmp_level,
  output wire ra5_cmp_level
);

  // reset image of the control register, picked apart field by field
  localparam [7:0] ctrl_reset = `CMP_CTRL_RESET;

  // writable part of the control register
  reg cmp2_polarity_invert;
  reg cmp1_polarity_invert;
  reg input_switch_select;
  reg [2:0] comparator_mode_select;

  // next values of the writable part
  reg next_cmp2_polarity_invert;
  reg next_cmp1_polarity_invert;
  reg next_input_switch_select;
  reg [2:0] next_comparator_mode_select;

  // results held for software, and the unsynchronised pin levels
  wire cmp1_result;
  wire cmp2_result;
  wire cmp1_pin_level;
  wire cmp2_pin_level;

  // decoded mode and bus strobes
  wire mode_off;
  wire mode_pinout;
  wire ctrl_hit;
  wire ctrl_write;
  wire ctrl_read;
  wire [7:0] comparator_control;
  reg [7:0] next_rdata;

  assign mode_off = (comparator_mode_select == `CMP_MODE_OFF);
  assign mode_pinout = (comparator_mode_select == `CMP_MODE_PINOUT);
  assign ctrl_hit = (reg_addr == `CMP_CTRL_ADDR);

  // only the one mapped address answers; other addresses are ignored
  assign ctrl_write = reg_wr & ctrl_hit;
  assign ctrl_read = reg_rd & ctrl_hit;

  // both comparators run unless the mode turns them off
  assign cmp1_enable = ~mode_off;
  assign cmp2_enable = ~mode_off;

  // next control values; result bits are never taken from the bus
  always @* begin
    next_cmp2_polarity_invert = cmp2_polarity_invert;
    next_cmp1_polarity_invert = cmp1_polarity_invert;
    next_input_switch_select = input_switch_select;
    next_comparator_mode_select = comparator_mode_select;
    if (ctrl_write) begin
      next_cmp2_polarity_invert = reg_wdata[`CMP_BIT_CMP2_INV];
      next_cmp1_polarity_invert = reg_wdata[`CMP_BIT_CMP1_INV];
      next_input_switch_select = reg_wdata[`CMP_BIT_INPUT_SWITCH];
      next_comparator_mode_select = reg_wdata[`CMP_MODE_HI:`CMP_MODE_LO];
    end
  end

  // control register flops; a new setting acts from the cycle after the write
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp2_polarity_invert <= ctrl_reset[`CMP_BIT_CMP2_INV];
      cmp1_polarity_invert <= ctrl_reset[`CMP_BIT_CMP1_INV];
      input_switch_select <= ctrl_reset[`CMP_BIT_INPUT_SWITCH];
      comparator_mode_select <= ctrl_reset[`CMP_MODE_HI:`CMP_MODE_LO];
    end else begin
      cmp2_polarity_invert <= next_cmp2_polarity_invert;
      cmp1_polarity_invert <= next_cmp1_polarity_invert;
      input_switch_select <= next_input_switch_select;
      comparator_mode_select <= next_comparator_mode_select;
    end
  end

  // comparator 1 input routing from mode field and input switch
  always @* begin
    case (comparator_mode_select)
      `CMP_MODE_MUX4_VREF: begin
        // reference on the plus input, RA3 or RA0 on the minus input
        cmp1_noninverting_input = `CMP_SRC_VREF;
        if (input_switch_select) begin
          cmp1_inverting_input = `CMP_SRC_RA3;
        end else begin
          cmp1_inverting_input = `CMP_SRC_RA0;
        end
      end
      `CMP_MODE_OFF: begin
        // comparator disconnected
        cmp1_noninverting_input = `CMP_SRC_NONE;
        cmp1_inverting_input = `CMP_SRC_NONE;
      end
      default: begin
        // fixed pin pair, RA3 against RA0
        cmp1_noninverting_input = `CMP_SRC_RA3;
        cmp1_inverting_input = `CMP_SRC_RA0;
      end
    endcase
  end

  // comparator 2 input routing from mode field and input switch
  always @* begin
    case (comparator_mode_select)
      `CMP_MODE_MUX4_VREF: begin
        // reference on the plus input, RA2 or RA1 on the minus input
        cmp2_noninverting_input = `CMP_SRC_VREF;
        if (input_switch_select) begin
          cmp2_inverting_input = `CMP_SRC_RA2;
        end else begin
          cmp2_inverting_input = `CMP_SRC_RA1;
        end
      end
      `CMP_MODE_OFF: begin
        // comparator disconnected
        cmp2_noninverting_input = `CMP_SRC_NONE;
        cmp2_inverting_input = `CMP_SRC_NONE;
      end
      default: begin
        // fixed pin pair, RA2 against RA1
        cmp2_noninverting_input = `CMP_SRC_RA2;
        cmp2_inverting_input = `CMP_SRC_RA1;
      end
    endcase
  end

  // comparator 1 channel
  cmp_channel u_cmp1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_level(cmp1_raw),
    .enable(cmp1_enable),
    .invert(cmp1_polarity_invert),
    .result(cmp1_result),
    .pin_level(cmp1_pin_level)
  );

  // comparator 2 channel
  cmp_channel u_cmp2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_level(cmp2_raw),
    .enable(cmp2_enable),
    .invert(cmp2_polarity_invert),
    .result(cmp2_result),
    .pin_level(cmp2_pin_level)
  );

  // pin muxes switch to the unsynchronised, polarity-applied comparator levels in pin output mode
  assign ra4_cmp_select = mode_pinout;
  assign ra5_cmp_select = mode_pinout;
  assign ra4_cmp_level = mode_pinout & cmp1_pin_level;
  assign ra5_cmp_level = mode_pinout & cmp2_pin_level;

  // assembled register image
  assign comparator_control = {cmp2_result,
                               cmp1_result,
                               cmp2_polarity_invert,
                               cmp1_polarity_invert,
                               input_switch_select,
                               comparator_mode_select};

  // read data: the image for a mapped read, zero in every other cycle
  always @* begin
    next_rdata = 8'h00;
    if (ctrl_read) begin
      next_rdata = comparator_control;
    end
  end

  // read data stand one cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // dual_comparator_control

// >>> dual_comparator_control_chk.sv
// checker for the comparator control block, watching its ports only
// assumes clk rising edge and sys_rst active high
`timescale 1ns/100ps
module dual_comparator_control_chk (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // comparator side
  input wire cmp1_raw,
  input wire cmp2_raw,
  input wire [2:0] cmp1_noninverting_input,
  input wire [2:0] cmp1_inverting_input,
  input wire [2:0] cmp2_noninverting_input,
  input wire [2:0] cmp2_inverting_input,
  input wire cmp1_enable,
  input wire cmp2_enable,
  input wire ra4_cmp_select,
  input wire ra5_cmp_select,
  input wire ra4_cmp_level,
  input wire ra5_cmp_level
);
  reg [7:0] ctl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadow of the writable control bits
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) ctl <= 8'h07;
    else if (reg_wr && reg_addr == 4'h0) ctl <= reg_wdata & 8'h3F;
  sequence s_rd0; reg_rd && reg_addr == 4'h0; endsequence
  sequence s_quiet; ($stable(cmp1_raw) && $stable(ctl)) [*6]; endsequence
  property p_read; s_rd0 |=> reg_rdata[5:0] == ctl[5:0]; endproperty
  a_read: assert property (p_read) else $error("control image wrong");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_off; s_rd0 ##0 ctl[2:0] == 3'h7 ##0 $past(ctl[2:0]) == 3'h7 |=>
    reg_rdata[7:6] == 2'b00; endproperty
  a_off: assert property (p_off) else $error("result bits set while off");
  property p_unmap; reg_rd && reg_addr != 4'h0 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_result;
    s_quiet ##0 s_rd0 ##0 ctl[2:0] != 3'h7 |=> reg_rdata[6] == $past(cmp1_raw ^ ctl[4]);
  endproperty
  a_result: assert property (p_result) else $error("comparator 1 result wrong");
  property p_en; cmp1_enable == (ctl[2:0] != 3'h7) && cmp2_enable == cmp1_enable; endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_pinsel; ra4_cmp_select == (ctl[2:0] == 3'h3) && ra5_cmp_select == ra4_cmp_select;
  endproperty
  a_pinsel: assert property (p_pinsel) else $error("pin select wrong");
  property p_pin; ra4_cmp_select |->
    ra4_cmp_level == (cmp1_raw ^ ctl[4]) && ra5_cmp_level == (cmp2_raw ^ ctl[5]); endproperty
  a_pin: assert property (p_pin) else $error("pin level wrong");
  property p_vref; ctl[2:0] == 3'h6 |->
    cmp1_noninverting_input == 3'h6 && cmp2_noninverting_input == 3'h6; endproperty
  a_vref: assert property (p_vref) else $error("reference not on plus inputs");
  property p_sw; ctl[2:0] == 3'h6 |-> cmp1_inverting_input == (ctl[3] ? 3'h3 : 3'h0)
    && cmp2_inverting_input == (ctl[3] ? 3'h2 : 3'h1); endproperty
  a_sw: assert property (p_sw) else $error("input switch wrong");
endmodule // dual_comparator_control_chk
bind dual_comparator_control dual_comparator_control_chk u_chk (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp1_raw, .cmp2_raw, .cmp1_noninverting_input,
  .cmp1_inverting_input, .cmp2_noninverting_input, .cmp2_inverting_input, .cmp1_enable,
  .cmp2_enable, .ra4_cmp_select, .ra5_cmp_select, .ra4_cmp_level, .ra5_cmp_level);

// >>> dual_comparator_control_bench.sv
// self-checking bench for the comparator control block
// assumes the register port answers one cycle after a read strobe
`timescale 1ns/100ps
module dual_comparator_control_bench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] a = 4'h0;
  reg [7:0] d = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg r1 = 1'b0;
  reg r2 = 1'b0;
  wire [7:0] q;
  wire [2:0] p1, m1, p2, m2;
  wire e1, e2, s4, s5, l4, l5;
  integer n_errors = 0;
  integer n_compared = 0;
  integer cyc = 0;
  dual_comparator_control u_dual_comparator_control (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(a), .reg_wdata(d), .reg_wr(wr), .reg_rd(rd), .reg_rdata(q), .cmp1_raw(r1),
    .cmp2_raw(r2), .cmp1_noninverting_input(p1), .cmp1_inverting_input(m1),
    .cmp2_noninverting_input(p2), .cmp2_inverting_input(m2), .cmp1_enable(e1),
    .cmp2_enable(e2), .ra4_cmp_select(s4), .ra5_cmp_select(s5), .ra4_cmp_level(l4),
    .ra5_cmp_level(l5));
  // clock and hang limit
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wrt(input [3:0] ad, input [7:0] dt);
    begin
      @(posedge clk) begin wr <= 1'b1; a <= ad; d <= dt; end
      @(posedge clk) wr <= 1'b0;
      #1;
    end
  endtask
  task rdc(input [3:0] ad, input [7:0] exp);
    begin
      @(posedge clk) begin rd <= 1'b1; a <= ad; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(q, exp);
    end
  endtask
  task t_routing;
    begin
      rdc(4'h0, 8'h07);
      wrt(4'h0, 8'h16);
      chk({e1, e2, p1, p2}, {2'b11, 3'h6, 3'h6});
      chk({2'b00, m1, m2}, {2'b00, 3'h0, 3'h1});
      wrt(4'h0, 8'h1E);
      chk({2'b00, m1, m2}, {2'b00, 3'h3, 3'h2});
      wrt(4'h0, 8'hFF);
      rdc(4'h0, 8'h3F);
      $display("routing test done");
    end
  endtask
  task t_results;
    begin
      @(posedge clk) r1 <= 1'b1;
      wrt(4'h0, 8'h03);
      repeat (6) @(posedge clk);
      rdc(4'h0, 8'h43);
      chk({4'h0, s5, s4, l4, l5}, 8'h0E);
      wrt(4'h0, 8'h33);
      rdc(4'h0, 8'hB3);
      chk({6'h00, l4, l5}, 8'h01);
      wrt(4'h5, 8'h00);
      rdc(4'h5, 8'h00);
      rdc(4'h0, 8'hB3);
      $display("result test done");
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_routing;
    t_results;
    print_verdict;
  end
endmodule // dual_comparator_control_bench
